/* core/dma_engine.sv */
// How it works
// - four channels, channel 0 highest fixed priority
// - arbitrate the cycle before first bus clock
// - get bus, transfer, ack on requester cycle
// - block end: flag, interrupt and bus release on one edge
// - continuous policy keeps bus while request stays
// - resample request after ack drops, then each clock
// - direct item is one unlatched bus cycle
// - direct uses device A counter, ack asserted
// - direct dir 0 reads, dir 1 writes addressed
// - direct best spacing three or two clocks
// - size bit sets bytes; length is the item count
// - counters fixed, up or down per channel
// - indirect reads into holder, then writes
// - indirect ack only on device B cycle
// - indirect dir 0 A to B, 1 B to A
// - indirect best spacing bounded per policy
// - indirect item updates both address counters
// - one interrupt output per channel
// - eight software registers per channel
// - policy 0 releases, 1 holds while needed
// - software request bit acts like request pin
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module dma_engine import dma_pkg::*; #(
    parameter int AW = 32,
    parameter int LW = 16
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // core bus master
    output logic                     cb_req,
    input  wire logic                cb_gnt,
    output logic                     cb_cyc,
    output logic                     cb_wr,
    output logic                     cb_size,
    output logic      [AW-1:0]       cb_addr,
    output logic      [31:0]         cb_wdata,
    input  wire logic [31:0]         cb_rdata,
    input  wire logic                cb_ready,
    // peripherals
    input  wire logic [NUM_CH-1:0]   channel_transfer_request,
    output logic      [NUM_CH-1:0]   chan_ack,
    output logic      [NUM_CH-1:0]   chan_irq
);

    // ==========================================================
    // storage
    logic [AW-1:0]     device_a_address_counter [NUM_CH];
    logic [AW-1:0]     a_start_ff               [NUM_CH];
    logic [AW-1:0]     device_b_address_counter [NUM_CH];
    logic [AW-1:0]     b_start_ff               [NUM_CH];
    logic [LW-1:0]     block_length_counter     [NUM_CH];
    logic [LW-1:0]     len_reload_ff            [NUM_CH];
    logic [CTL_W-1:0]  channel_control_register [NUM_CH];
    logic [NUM_CH-1:0] done_ff;
    logic [NUM_CH-1:0] irq_ff;
    logic [NUM_CH-1:0] req_s1_ff;
    logic [NUM_CH-1:0] req_s2_ff;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] chan_active;

    eng_state_e        st_ff;
    logic [CHW-1:0]    cur_ff;
    logic              cb_req_ff;
    logic              cb_cyc_ff;
    logic              cb_wr_ff;
    logic              cb_size_ff;
    logic [AW-1:0]     cb_addr_ff;
    logic [31:0]       cb_wdata_ff;
    logic [NUM_CH-1:0] chan_ack_ff;

    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic [31:0]       rd_data;
    logic              apb_wr;
    logic [4:0]        reg_ofs;
    logic [CHW-1:0]    reg_ch;

    logic              arb_any;
    logic [CHW-1:0]    arb_idx;
    logic [CHW-1:0]    sel;
    logic              ind_cur;
    logic              dir_cur;
    logic              bpc_cur;
    logic              item_done;
    logic              last_item;
    logic              block_end;
    logic              go_ind;
    logic              go_dir;
    logic [AW-1:0]     go_addr;
    logic              go_wr;
    logic              go_ack;

    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign cb_req   = cb_req_ff;
    assign cb_cyc   = cb_cyc_ff;
    assign cb_wr    = cb_wr_ff;
    assign cb_size  = cb_size_ff;
    assign cb_addr  = cb_addr_ff;
    assign cb_wdata = cb_wdata_ff;
    assign chan_ack = chan_ack_ff;
    assign chan_irq = irq_ff;

    // ==========================================================
    // request pins: two-flop synchroniser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_s1_ff <= '0;
            req_s2_ff <= '0;
        end else begin
            req_s1_ff <= channel_transfer_request;
            req_s2_ff <= req_s1_ff;
        end
    end

    // ==========================================================
    // apb slave: one wait-free access phase, upper half unmapped
    assign reg_ofs = {paddr[4:2], 2'b00};
    assign reg_ch  = paddr[CH_SEL_LSB+CHW-1:CH_SEL_LSB];
    assign apb_wr  = psel & penable & pready_ff & pwrite & ~paddr[MAP_TOP_BIT];

    always_comb begin
        rd_data = '0;
        case (reg_ofs)
            OFS_A_CNT:      rd_data = 32'(device_a_address_counter[reg_ch]);
            OFS_A_START:    rd_data = 32'(a_start_ff[reg_ch]);
            OFS_B_CNT:      rd_data = 32'(device_b_address_counter[reg_ch]);
            OFS_B_START:    rd_data = 32'(b_start_ff[reg_ch]);
            OFS_LEN_CNT:    rd_data = 32'(block_length_counter[reg_ch]);
            OFS_LEN_RELOAD: rd_data = 32'(len_reload_ff[reg_ch]);
            OFS_CTRL:       rd_data = 32'(channel_control_register[reg_ch]);
            OFS_STAT:       rd_data = 32'({chan_active[reg_ch], done_ff[reg_ch]});
            default:        rd_data = '0;
        endcase
        if (paddr[MAP_TOP_BIT]) begin
            rd_data = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & paddr[MAP_TOP_BIT];
            if (psel & ~penable) begin
                prdata_ff <= rd_data;
            end
        end
    end

    // ==========================================================
    // address step: freeze, or one/two up/down, whatever the item size
    function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a,
                                                 input logic [1:0]    f,
                                                 input logic          upd);
        logic [AW-1:0] d;
        d = f[STEP_BIG] ? AW'(2) : AW'(1);
        if (!upd) begin
            step_addr = a;
        end else if (f[STEP_DOWN]) begin
            step_addr = a - d;
        end else begin
            step_addr = a + d;
        end
    endfunction

    // ==========================================================
    // per-channel register sets; engine updates win over software
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic             wr_ch;
            logic             upd_ch;
            logic             nxt_done;
            logic [CTL_W-1:0] ctl;

            assign ctl    = channel_control_register[gi];
            assign wr_ch  = apb_wr & (reg_ch == CHW'(gi));
            assign upd_ch = item_done & (cur_ff == CHW'(gi));
            assign pend[gi] = ctl[CTL_EN] & (req_s2_ff[gi] | ctl[CTL_SOFTWARE_REQUEST_BIT])
                              & (block_length_counter[gi] != '0);
            assign chan_active[gi] = ctl[CTL_EN] & (block_length_counter[gi] != '0);
            // a completion in the same cycle as a write-one clear survives
            assign nxt_done = (block_end & (cur_ff == CHW'(gi)))
                            | (done_ff[gi] & ~(wr_ch & (reg_ofs == OFS_STAT)
                                               & pwdata[ST_DONE]));

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    device_a_address_counter[gi] <= '0;
                    a_start_ff[gi]               <= '0;
                    device_b_address_counter[gi] <= '0;
                    b_start_ff[gi]               <= '0;
                    block_length_counter[gi]     <= '0;
                    len_reload_ff[gi]            <= '0;
                    channel_control_register[gi] <= CTRL_RST;
                    done_ff[gi]                  <= 1'b0;
                    irq_ff[gi]                   <= 1'b0;
                end else begin
                    done_ff[gi] <= nxt_done;
                    irq_ff[gi]  <= nxt_done & ctl[CTL_IRQEN];
                    if (wr_ch) begin
                        case (reg_ofs)
                            OFS_A_CNT:      device_a_address_counter[gi] <= pwdata[AW-1:0];
                            OFS_A_START:    a_start_ff[gi]               <= pwdata[AW-1:0];
                            OFS_B_CNT:      device_b_address_counter[gi] <= pwdata[AW-1:0];
                            OFS_B_START:    b_start_ff[gi]               <= pwdata[AW-1:0];
                            OFS_LEN_CNT:    block_length_counter[gi]     <= pwdata[LW-1:0];
                            OFS_LEN_RELOAD: len_reload_ff[gi]            <= pwdata[LW-1:0];
                            OFS_CTRL:       channel_control_register[gi] <= pwdata[CTL_W-1:0];
                            default:        ;
                        endcase
                    end
                    // last assignment wins: only the counters are overridden
                    if (upd_ch) begin
                        device_a_address_counter[gi] <= step_addr(
                            device_a_address_counter[gi],
                            ctl[CTL_ASTEP+1:CTL_ASTEP], ctl[CTL_AUPD]);
                        if (ctl[CTL_IND]) begin
                            device_b_address_counter[gi] <= step_addr(
                                device_b_address_counter[gi],
                                ctl[CTL_BSTEP+1:CTL_BSTEP], ctl[CTL_BUPD]);
                        end
                        block_length_counter[gi] <= block_length_counter[gi] - LW'(1);
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // channel choice and launch of an item's first bus cycle
    dma_prio_arb #(
        .N  (NUM_CH),
        .IW (CHW)
    ) u_arb (
        .req (pend),
        .any (arb_any),
        .idx (arb_idx)
    );

    assign sel     = (st_ff == ST_GNT) ? arb_idx : cur_ff;
    assign go_ind  = channel_control_register[sel][CTL_IND];
    assign go_dir  = channel_control_register[sel][CTL_DIR];
    // first cycle: direct and indirect dir 0 go through A, dir 1 through B
    assign go_addr = (go_ind & go_dir) ? device_b_address_counter[sel]
                                       : device_a_address_counter[sel];
    assign go_wr   = ~go_ind & go_dir;
    assign go_ack  = ~go_ind | go_dir;

    assign ind_cur   = channel_control_register[cur_ff][CTL_IND];
    assign dir_cur   = channel_control_register[cur_ff][CTL_DIR];
    assign bpc_cur   = channel_control_register[cur_ff][CTL_BPC];
    assign item_done = cb_cyc_ff & cb_ready
                       & (((st_ff == ST_XA) & ~ind_cur) | (st_ff == ST_XB));
    assign last_item = block_length_counter[cur_ff] == LW'(1);
    assign block_end = item_done & last_item;

    // ==========================================================
    // engine sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff       <= ST_IDLE;
            cur_ff      <= '0;
            cb_req_ff   <= 1'b0;
            cb_cyc_ff   <= 1'b0;
            cb_wr_ff    <= 1'b0;
            cb_size_ff  <= 1'b0;
            cb_addr_ff  <= '0;
            cb_wdata_ff <= '0;
            chan_ack_ff <= '0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (arb_any) begin
                        cb_req_ff <= 1'b1;
                        st_ff     <= ST_GNT;
                    end
                end
                ST_GNT: begin
                    if (!arb_any) begin
                        cb_req_ff <= 1'b0;
                        st_ff     <= ST_IDLE;
                    end else if (cb_gnt) begin
                        cur_ff      <= arb_idx;
                        cb_cyc_ff   <= 1'b1;
                        cb_addr_ff  <= go_addr;
                        cb_wr_ff    <= go_wr;
                        cb_size_ff  <= channel_control_register[arb_idx][CTL_TCS];
                        chan_ack_ff <= go_ack ? (NUM_CH'(1) << arb_idx) : '0;
                        st_ff       <= ST_XA;
                    end
                end
                ST_XA: begin
                    if (cb_ready) begin
                        if (ind_cur) begin
                            // data held here until the write cycle
                            cb_wdata_ff <= cb_rdata;
                            cb_addr_ff  <= dir_cur ? device_a_address_counter[cur_ff]
                                                   : device_b_address_counter[cur_ff];
                            cb_wr_ff    <= 1'b1;
                            chan_ack_ff <= dir_cur ? '0 : (NUM_CH'(1) << cur_ff);
                            st_ff       <= ST_XB;
                        end else begin
                            // fly-by: no copy of the data is taken
                            cb_cyc_ff   <= 1'b0;
                            chan_ack_ff <= '0;
                            if (last_item || !bpc_cur) begin
                                cb_req_ff <= 1'b0;
                                st_ff     <= ST_IDLE;
                            end else begin
                                st_ff <= ST_NEXT;
                            end
                        end
                    end
                end
                ST_XB: begin
                    if (cb_ready) begin
                        cb_cyc_ff   <= 1'b0;
                        chan_ack_ff <= '0;
                        if (last_item || !bpc_cur) begin
                            cb_req_ff <= 1'b0;
                            st_ff     <= ST_IDLE;
                        end else begin
                            st_ff <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    // ack is low now; higher channels cannot cut in
                    if (pend[cur_ff]) begin
                        cb_cyc_ff   <= 1'b1;
                        cb_addr_ff  <= go_addr;
                        cb_wr_ff    <= go_wr;
                        cb_size_ff  <= channel_control_register[cur_ff][CTL_TCS];
                        chan_ack_ff <= go_ack ? (NUM_CH'(1) << cur_ff) : '0;
                        st_ff       <= ST_XA;
                    end else begin
                        cb_req_ff <= 1'b0;
                        st_ff     <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff     <= ST_IDLE;
                    cb_req_ff <= 1'b0;
                    cb_cyc_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // checks
    localparam int GAP_DC = GAP_DIRECT_CONT;
    logic [LW-1:0] len_cur;
    assign len_cur = block_length_counter[cur_ff];

    default clocking cb_clk @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_ack_single: assert property ($onehot0(chan_ack_ff))
        else $error("more than one acknowledge active");
    a_prio_zero: assert property ((st_ff == ST_GNT) && cb_gnt && pend[0]
                                  |=> cur_ff == '0 && st_ff == ST_XA)
        else $error("channel 0 lost arbitration");
    a_arb_then_t1: assert property ((st_ff == ST_GNT) && cb_gnt && arb_any
                                    |=> cb_cyc_ff && cb_req_ff)
        else $error("bus cycle did not follow arbitration");
    a_cyc_has_bus: assert property (cb_cyc_ff |-> cb_req_ff)
        else $error("bus cycle without bus request");
    a_direct_ack: assert property ((st_ff == ST_XA) && !ind_cur
                                   |-> chan_ack_ff[cur_ff] && cb_wr_ff == dir_cur)
        else $error("direct cycle without ack or wrong direction");
    a_ind_b_ack: assert property ((st_ff == ST_XA) && ind_cur && cb_ready
                                  |-> chan_ack_ff[cur_ff] == dir_cur
                                  ##1 chan_ack_ff[cur_ff] == !dir_cur && cb_wr_ff)
        else $error("indirect ack not on device B cycle");
    a_len_dec: assert property (item_done |=> len_cur == $past(len_cur) - LW'(1))
        else $error("block length did not step down by one");
    a_end_release: assert property (block_end
                                    |=> !cb_req_ff && done_ff[$past(cur_ff)])
        else $error("block end without flag or release");
    a_intermit_rel: assert property (item_done && !bpc_cur |=> !cb_req_ff)
        else $error("intermittent channel kept the bus");
    a_cont_keep: assert property ((st_ff == ST_NEXT) && pend[cur_ff]
                                  |=> (st_ff == ST_XA) && cb_req_ff ##[0:GAP_DC] cb_cyc_ff)
        else $error("continuous channel released the bus");

    c_direct_item: cover property (item_done && !ind_cur);
    c_indirect_item: cover property (item_done && ind_cur);
    c_cont_next: cover property ((st_ff == ST_NEXT) ##1 (st_ff == ST_XA));
    c_block_end: cover property (block_end);

endmodule

`default_nettype wire

/* core/dma_pkg.sv */
`default_nettype none

package dma_pkg;

    // ==========================================================
    // channel layout
    localparam int NUM_CH       = 4;
    localparam int CHW          = 2;
    localparam int REGS_PER_CH  = 8;
    localparam int CH_SEL_LSB   = 5;
    localparam int MAP_TOP_BIT  = 7;

    // ==========================================================
    // register offsets within a channel (byte addresses)
    localparam logic [4:0] OFS_A_CNT      = 5'h00;
    localparam logic [4:0] OFS_A_START    = 5'h04;
    localparam logic [4:0] OFS_B_CNT      = 5'h08;
    localparam logic [4:0] OFS_B_START    = 5'h0C;
    localparam logic [4:0] OFS_LEN_CNT    = 5'h10;
    localparam logic [4:0] OFS_LEN_RELOAD = 5'h14;
    localparam logic [4:0] OFS_CTRL       = 5'h18;
    localparam logic [4:0] OFS_STAT       = 5'h1C;

    // ==========================================================
    // channel_control_register fields
    localparam int CTL_EN     = 0;
    localparam int CTL_DIR    = 1;
    localparam int CTL_IND    = 2;
    localparam int CTL_BPC    = 3;
    localparam int CTL_TCS    = 4;
    localparam int CTL_SOFTWARE_REQUEST_BIT   = 5;
    localparam int CTL_IRQEN  = 6;
    localparam int CTL_AUPD   = 7;
    localparam int CTL_BUPD   = 8;
    localparam int CTL_ASTEP  = 9;
    localparam int CTL_BSTEP  = 11;
    localparam int CTL_W      = 13;
    localparam logic [CTL_W-1:0] CTRL_RST = 13'h0000;

    // step field: bit 0 picks a step of two, bit 1 picks decrement
    localparam int STEP_BIG   = 0;
    localparam int STEP_DOWN  = 1;

    // ==========================================================
    // status register fields
    localparam int ST_DONE    = 0;
    localparam int ST_ACTIVE  = 1;

    // ==========================================================
    // best-case item spacing in clocks
    localparam int GAP_DIRECT_INTERMIT = 3;
    localparam int GAP_DIRECT_CONT     = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GNT,
        ST_XA,
        ST_XB,
        ST_NEXT
    } eng_state_e;

endpackage

`default_nettype wire

/* core/dma_prio_arb.sv */
`timescale 1ns/10ps
`default_nettype none

module dma_prio_arb #(
    parameter int N  = 4,
    parameter int IW = 2
) (
    // requests
    input  wire logic [N-1:0]  req,
    // result
    output logic               any,
    output logic [IW-1:0]      idx
);

    // lowest index wins: scan from the top so channel 0 overwrites last
    always_comb begin
        any = |req;
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req[k]) begin
                idx = IW'(k);
            end
        end
    end

endmodule

`default_nettype wire

/* verif/dma_bus_partner.sv */
`timescale 1ns/10ps
`default_nettype none

module dma_bus_partner #(
    parameter logic [31:0] PAT = 32'h5A5A_0000
) (
    // control
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    // core bus
    input  wire logic        cb_req,
    output logic             cb_gnt,
    input  wire logic        cb_cyc,
    input  wire logic [31:0] cb_addr,
    output logic             cb_ready,
    output logic [31:0]      cb_rdata
);
    logic        held_ff;
    logic        wait_ff;
    logic [31:0] spin_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            held_ff <= 1'h0;
            wait_ff <= 1'h0;
            spin_ff <= 32'h0;
        end else begin
            held_ff <= cb_req;
            wait_ff <= cb_cyc & ~cb_ready;
            spin_ff <= spin_ff + 32'h1;
        end
    end

    // slow: grant and ready each one clock late
    assign cb_gnt   = cb_req & (~slow | held_ff);
    assign cb_ready = cb_cyc & (~slow | wait_ff);
    // junk outside the ready cycle so stale data is never mistaken
    assign cb_rdata = cb_ready ? (cb_addr ^ PAT) : ~spin_ff;
endmodule

`default_nettype wire

/* verif/four_channel_dma_engine_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module four_channel_dma_engine_tb_top import dma_pkg::*;;
    localparam logic [31:0] PAT = 32'h5A5A_0000;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, slow, sz;
    logic cb_req, cb_gnt, cb_cyc, cb_wr, cb_size, cb_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cb_addr, cb_wdata, cb_rdata, r, a0, seed;
    logic [3:0] channel_transfer_request, chan_ack, chan_irq;
    logic [69:0] expq[$];
    logic [69:0] e;
    int mismatches, checks_done;

    dma_engine dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cb_req(cb_req), .cb_gnt(cb_gnt), .cb_cyc(cb_cyc), .cb_wr(cb_wr),
        .cb_size(cb_size), .cb_addr(cb_addr), .cb_wdata(cb_wdata), .cb_rdata(cb_rdata),
        .cb_ready(cb_ready), .channel_transfer_request(channel_transfer_request),
        .chan_ack(chan_ack), .chan_irq(chan_irq));
    dma_bus_partner #(.PAT(PAT)) bus_u (.sys_clk(sys_clk), .rst(rst), .slow(slow),
        .cb_req(cb_req), .cb_gnt(cb_gnt), .cb_cyc(cb_cyc), .cb_addr(cb_addr),
        .cb_ready(cb_ready), .cb_rdata(cb_rdata));

    // ==========================================================
    // shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input logic [68:0] got, input logic [68:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        r = w ? {31'h0, pslverr} : prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [4:0] ofs);
        return {1'h0, 2'(ch), ofs};
    endfunction
    task automatic note(input logic v, input logic [3:0] k, input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        expq.push_back({v, k, w, a, d});
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (expq.size() != 0 && n < 500) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    // ==========================================================
    // monitor takes the oldest note at each finished bus cycle
    always @(posedge sys_clk) begin
        if (cb_cyc === 1'h1 && cb_ready === 1'h1) begin
            e = (expq.size() != 0) ? expq.pop_front() : '1;
            chk_cyc({chan_ack, cb_wr, cb_addr, e[69] ? cb_wdata : 32'h0}, e[68:0]);
            chk_reg({31'h0, cb_size}, {31'h0, sz});
        end
    end

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    initial begin
        seed = 32'hC407;
        rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0;
        pwdata = 32'h0; slow = 1'h0; channel_transfer_request = 4'h0;
        sz = 1'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        apb(1'h0, ra(0, OFS_CTRL), 32'h0);
        chk_reg(r, 32'h0);
        chk_reg({24'h0, chan_irq, chan_ack}, 32'h0);
        apb(1'h0, 8'h80, 32'h0);
        chk_reg({pslverr, r[30:0]}, 32'h8000_0000);
        // channel 0: direct read, continuous, held request
        a0 = $random(seed) & 32'h0000_FFF0;
        apb(1'h1, ra(0, OFS_A_CNT), a0);
        apb(1'h1, ra(0, OFS_LEN_CNT), 32'h3);
        apb(1'h1, ra(0, OFS_CTRL), 32'h00C9);
        for (int i = 0; i < 3; i++) note(1'h0, 4'h1, 1'h0, a0 + i, 32'h0);
        channel_transfer_request[0] <= 1'h1;
        drain();
        chk_reg({31'h0, chan_irq[0]}, 32'h1);
        channel_transfer_request[0] <= 1'h0;
        apb(1'h0, ra(0, OFS_A_CNT), 32'h0);
        chk_reg(r, a0 + 32'h3);
        apb(1'h0, ra(0, OFS_LEN_CNT), 32'h0);
        chk_reg(r, 32'h0);
        apb(1'h0, ra(0, OFS_STAT), 32'h0);
        chk_reg(r, 32'h1);
        apb(1'h1, ra(0, OFS_STAT), 32'h1);
        repeat (2) @(posedge sys_clk);
        chk_reg({31'h0, chan_irq[0]}, 32'h0);
        // channel 1: indirect B to A by software request, slow bus
        slow <= 1'h1;
        apb(1'h1, ra(1, OFS_A_CNT), 32'h40);
        apb(1'h1, ra(1, OFS_B_CNT), 32'h200);
        apb(1'h1, ra(1, OFS_LEN_CNT), 32'h2);
        apb(1'h1, ra(1, OFS_CTRL), 32'h1967);
        note(1'h0, 4'h2, 1'h0, 32'h200, 32'h0);
        note(1'h1, 4'h0, 1'h1, 32'h40, 32'h200 ^ PAT);
        note(1'h0, 4'h2, 1'h0, 32'h1FE, 32'h0);
        note(1'h1, 4'h0, 1'h1, 32'h40, 32'h1FE ^ PAT);
        drain();
        chk_reg({31'h0, chan_irq[1]}, 32'h1);
        chk_reg({31'h0, cb_req}, 32'h0);
        apb(1'h0, ra(1, OFS_B_CNT), 32'h0);
        chk_reg(r, 32'h1FC);
        // channels 2 and 3 together: lower number wins
        slow <= 1'($random(seed));
        sz = 1'h1;
        apb(1'h1, ra(2, OFS_A_CNT), 32'h300);
        apb(1'h1, ra(2, OFS_B_CNT), 32'h340);
        apb(1'h1, ra(3, OFS_A_CNT), 32'h380);
        apb(1'h1, ra(2, OFS_LEN_CNT), 32'h1);
        apb(1'h1, ra(3, OFS_LEN_CNT), 32'h1);
        apb(1'h1, ra(2, OFS_CTRL), 32'h0295);
        apb(1'h1, ra(3, OFS_CTRL), 32'h0493);
        note(1'h0, 4'h0, 1'h0, 32'h300, 32'h0);
        note(1'h1, 4'h4, 1'h1, 32'h340, 32'h300 ^ PAT);
        note(1'h0, 4'h8, 1'h1, 32'h380, 32'h0);
        channel_transfer_request <= 4'hC;
        drain();
        channel_transfer_request <= 4'h0;
        apb(1'h0, ra(2, OFS_A_CNT), 32'h0);
        chk_reg(r, 32'h302);
        apb(1'h0, ra(3, OFS_A_CNT), 32'h0);
        chk_reg(r, 32'h37F);
        chk_reg(expq.size(), 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
